// *** inc/sdc_pkg.sv ***
package sdc_pkg;
  // Register map, byte addresses on the processor bus
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] HC_STATE_OFF = 12'h000;
  localparam logic [ADDR_W-1:0] HC_LIMIT_OFF = 12'h300;
  localparam logic [ADDR_W-1:0] MODE_CTL_OFF = 12'h300;
  localparam logic [ADDR_W-1:0] SOFT_RESET_OFF = 12'h30c;
  localparam logic [ADDR_W-1:0] XFER_CFG_OFF = 12'h330;
  localparam logic [ADDR_W-1:0] RAM_WIN_OFF = 12'h400;

  // Soft reset register fields
  localparam int SR_FULL_BIT = 0;
  localparam int SR_CTRL_BIT = 1;
  localparam logic [31:0] SOFT_RESET_RST = 32'h0000_0000;

  // Transfer configuration fields
  localparam int CFG_DIR_BIT = 0;
  localparam int CFG_RUN_BIT = 1;
  localparam int CFG_BURST_LSB = 2;
  localparam int CFG_CNT_LSB = 8;
  localparam int CNT_W = 24;
  localparam logic [7:0] CFG_LOW_MASK = 8'h0f;
  localparam logic [31:0] XFER_CFG_RST = 32'h0000_0000;

  // Mode control fields used by this block
  localparam int MODE_REQ_POL_BIT = 5;
  localparam int MODE_ACK_POL_BIT = 6;
  localparam int MODE_WIDTH_BIT = 8;
  localparam logic [31:0] MODE_CTL_MASK = 32'h0000_0160;
  localparam logic [31:0] MODE_CTL_RST = 32'h0000_0000;
  localparam logic [31:0] HC_STATE_RST = 32'h0000_0000;

  // Bytes moved per access for each bus width
  localparam logic [CNT_W-1:0] BYTES_NARROW = 24'h000002;
  localparam logic [CNT_W-1:0] BYTES_WIDE = 24'h000004;

  // Accesses per request for each burst size code
  localparam logic [4:0] BEATS_SINGLE = 5'h01;
  localparam logic [4:0] BEATS_FOUR = 5'h04;
  localparam logic [4:0] BEATS_EIGHT = 5'h08;
  localparam logic [4:0] BEATS_SIXTEEN = 5'h10;

  typedef enum logic [2:0] {
    SDC_IDLE = 3'b001,
    SDC_BURST = 3'b010,
    SDC_GAP = 3'b100
  } sdc_state_t;
endpackage : sdc_pkg

// *** inc/sdc_buf_if.sv ***
`timescale 1ns/1ps
interface sdc_buf_if #(parameter int W = 32);
  logic inValid;
  logic inReady;
  logic [W-1:0] inData;
  logic outValid;
  logic outReady;
  logic [W-1:0] outData;
  logic flush;
  modport store (input inValid, output inReady, input inData,
                 output outValid, input outReady, output outData, input flush);
  modport user (output inValid, input inReady, output inData,
                input outValid, output outReady, input outData, output flush);
endinterface : sdc_buf_if

// *** verilog/sdc_pair_buf.sv ***
`timescale 1ns/1ps
module sdc_pair_buf #(
  parameter int W = 32,
  parameter int DEPTH = 2
) (
  input wire logic core_clk, // System clock
  input wire logic reset, // Synchronous, active high
  sdc_buf_if.store bus // Fill and drain sides
);
  import sdc_pkg::*;
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] slot_r [DEPTH];
  logic [PW-1:0] head_r;
  logic [PW-1:0] tail_r;
  logic [PW:0] fill_r;
  wire push = bus.inValid & bus.inReady;
  wire pop = bus.outValid & bus.outReady;
  wire [PW-1:0] headInc = (head_r == PW'(DEPTH - 1)) ? '0 : head_r + 1'b1;
  wire [PW-1:0] tailInc = (tail_r == PW'(DEPTH - 1)) ? '0 : tail_r + 1'b1;

  assign bus.inReady = (fill_r != (PW + 1)'(DEPTH)) & ~bus.flush;
  assign bus.outValid = (fill_r != '0) & ~bus.flush;
  assign bus.outData = slot_r[head_r];

  always_ff @(posedge core_clk) begin
    if (push) begin
      slot_r[tail_r] <= bus.inData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset || bus.flush) begin
      head_r <= '0;
      tail_r <= '0;
      fill_r <= '0;
    end else begin
      if (push) tail_r <= tailInc;
      if (pop) head_r <= headInc;
      fill_r <= fill_r + (PW + 1)'(push) - (PW + 1)'(pop);
    end
  end
endmodule : sdc_pair_buf

// *** verilog/sdc_slave_dma.sv ***
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////////////////////////
module sdc_slave_dma
  import sdc_pkg::*;
#(
  parameter int RAM_WORDS = 256
) (
  input wire logic core_clk, // System clock, 125 MHz
  input wire logic reset, // Synchronous, active high
  input wire logic cpuCs, // Register select
  input wire logic cpuWr, // One-cycle write strobe
  input wire logic cpuRd, // One-cycle read strobe
  input wire logic [sdc_pkg::ADDR_W-1:0] cpuAddr, // Byte address
  input wire logic [31:0] cpuWrData, // Write data
  output logic [31:0] cpuRdData_r, // Read data, one cycle after strobe
  output logic transferRequestOut_r, // Burst request, programmable level
  input wire logic transferAcknowledgeIn, // Access acknowledge, programmable level
  input wire logic [31:0] dmaDataIn, // Data written by the system
  output logic [31:0] dmaDataOut_r, // Data read by the system
  output logic dmaDataOe_r, // High while dmaDataOut_r is driven
  input wire logic ramGrant, // Internal RAM free for the engine
  output logic xferBusy_r // Transfer in progress
);
  import sdc_pkg::*;
  localparam int RAW = $clog2(RAM_WORDS);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Register bus decode
  logic [31:0] hcState_r;
  logic [31:0] modeCtl_r;
  logic [7:0] cfgLow_r;
  logic [CNT_W-1:0] remain_r;
  logic [CNT_W-1:0] fetchRem_r;
  logic [RAW-1:0] wrPtr_r;
  logic [RAW-1:0] rdPtr_r;
  logic [31:0] ramMem [RAM_WORDS];
  sdc_state_t state_r;
  sdc_state_t state_nxt;
  logic [4:0] beats_r;
  logic [4:0] beats_nxt;

  wire wrStb = cpuCs & cpuWr;
  wire rdStb = cpuCs & cpuRd;
  wire inRam = (cpuAddr >= RAM_WIN_OFF) && (cpuAddr < RAM_WIN_OFF + ADDR_W'(RAM_WORDS * 4));
  wire [RAW-1:0] ramIdx = RAW'((cpuAddr - RAM_WIN_OFF) >> 2);
  wire inHc = (cpuAddr == HC_STATE_OFF);
  wire wrHc = wrStb & inHc;
  wire wrMode = wrStb & (cpuAddr == MODE_CTL_OFF);
  wire wrSoft = wrStb & (cpuAddr == SOFT_RESET_OFF);
  wire wrCfg = wrStb & (cpuAddr == XFER_CFG_OFF);
  wire wrRam = wrStb & inRam;

  wire fullClr = wrSoft & cpuWrData[SR_FULL_BIT];
  wire ctrlClr = wrSoft & cpuWrData[SR_CTRL_BIT];
  wire allClr = reset | fullClr;
  wire hcClr = allClr | ctrlClr;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Mode and configuration fields
  // bus width selects bytes per access
  wire wideBus = modeCtl_r[MODE_WIDTH_BIT];
  wire reqPol = modeCtl_r[MODE_REQ_POL_BIT];
  wire ackPol = modeCtl_r[MODE_ACK_POL_BIT];
  wire runOn = cfgLow_r[CFG_RUN_BIT];
  wire dirOut = cfgLow_r[CFG_DIR_BIT];
  wire [1:0] burstSel = cfgLow_r[CFG_BURST_LSB +: 2];
  wire [CNT_W-1:0] step = wideBus ? BYTES_WIDE : BYTES_NARROW;
  wire ackActive = (transferAcknowledgeIn == ackPol);

  wire [4:0] burstBeats = (burstSel == 2'b00) ? BEATS_SINGLE :
                          (burstSel == 2'b01) ? BEATS_FOUR :
                          (burstSel == 2'b10) ? BEATS_EIGHT : BEATS_SIXTEEN;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer in the data path
  sdc_buf_if #(.W(32)) dbuf ();

  sdc_pair_buf #(.W(32), .DEPTH(2)) u_buf (
    .core_clk(core_clk),
    .reset(reset),
    .bus(dbuf.store)
  );

  // direction picks buffer source and sink
  wire canMove = dirOut ? dbuf.outValid : dbuf.inReady;
  wire access = (state_r == SDC_BURST) & ackActive & canMove & runOn;
  wire fetchGo = dirOut & runOn & (fetchRem_r != '0) & ramGrant;
  wire drainGo = ~dirOut & ramGrant;
  wire lastBytes = (remain_r <= step);
  wire [CNT_W-1:0] remainDec = lastBytes ? '0 : remain_r - step;
  wire [CNT_W-1:0] fetchDec = (fetchRem_r <= step) ? '0 : fetchRem_r - step;

  assign dbuf.inValid = dirOut ? fetchGo : access;
  assign dbuf.inData = dirOut ? ramMem[rdPtr_r] : dmaDataIn;
  assign dbuf.outReady = dirOut ? access : drainGo;
  // dropping the run bit flushes the buffer
  assign dbuf.flush = wrCfg | ~runOn;

  wire fetchTaken = dbuf.inValid & dbuf.inReady & dirOut;
  wire drainTaken = dbuf.outValid & dbuf.outReady & ~dirOut;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Request sequencer
  always_comb begin
    state_nxt = state_r;
    beats_nxt = beats_r;
    case (state_r)
      SDC_IDLE: begin
        // request only while enabled with bytes left
        if (runOn && remain_r != '0) begin
          state_nxt = SDC_BURST;
          beats_nxt = burstBeats;
        end
      end
      SDC_BURST: begin
        if (!runOn) begin
          state_nxt = SDC_IDLE;
        end else if (access) begin
          beats_nxt = beats_r - 5'h01;
          // stop at end of burst or count
          if (beats_r == 5'h01 || lastBytes) begin
            state_nxt = SDC_GAP;
          end
        end
      end
      SDC_GAP: begin
        state_nxt = SDC_IDLE;
      end
      default: begin
        state_nxt = SDC_IDLE;
      end
    endcase
  end

  wire reqOn = (state_nxt == SDC_BURST) & ~allClr & ~wrCfg;

  always_ff @(posedge core_clk) begin
    if (allClr || wrCfg) begin
      state_r <= SDC_IDLE;
      beats_r <= '0;
    end else begin
      state_r <= state_nxt;
      beats_r <= beats_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge core_clk) begin
    // host-side registers cleared by either reset bit
    if (hcClr) begin
      hcState_r <= HC_STATE_RST;
    end else if (wrHc) begin
      hcState_r <= cpuWrData;
    end
  end

  always_ff @(posedge core_clk) begin
    // interface registers cleared only by full reset
    if (allClr) begin
      modeCtl_r <= MODE_CTL_RST;
      cfgLow_r <= XFER_CFG_RST[7:0];
    end else begin
      if (wrMode) modeCtl_r <= cpuWrData & MODE_CTL_MASK;
      if (wrCfg) cfgLow_r <= cpuWrData[7:0] & CFG_LOW_MASK;
    end
  end

  always_ff @(posedge core_clk) begin
    // byte count loaded from bits 31..8
    if (allClr) begin
      remain_r <= XFER_CFG_RST[CFG_CNT_LSB +: CNT_W];
      fetchRem_r <= XFER_CFG_RST[CFG_CNT_LSB +: CNT_W];
    end else if (wrCfg) begin
      remain_r <= cpuWrData[CFG_CNT_LSB +: CNT_W];
      fetchRem_r <= cpuWrData[CFG_CNT_LSB +: CNT_W];
    end else begin
      // count falls by bytes per access
      if (access) remain_r <= remainDec;
      if (fetchTaken) fetchRem_r <= fetchDec;
    end
  end

  always_ff @(posedge core_clk) begin
    if (allClr || wrCfg) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      if (drainTaken) wrPtr_r <= wrPtr_r + 1'b1;
      if (fetchTaken) rdPtr_r <= rdPtr_r + 1'b1;
    end
  end

  // Engine drain wins over a processor write in the same cycle
  always_ff @(posedge core_clk) begin
    if (drainTaken) begin
      ramMem[wrPtr_r] <= wideBus ? dbuf.outData : {16'h0000, dbuf.outData[15:0]};
    end else if (wrRam) begin
      ramMem[ramIdx] <= cpuWrData;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Read-back and pins
  wire [31:0] cfgView = {remain_r, cfgLow_r};
  wire [31:0] rdMux = inHc ? hcState_r :
                      (cpuAddr == MODE_CTL_OFF) ? modeCtl_r :
                      (cpuAddr == XFER_CFG_OFF) ? cfgView :
                      inRam ? ramMem[ramIdx] : 32'h0000_0000;
  wire dataOut = dirOut & access;
  wire [31:0] outWord = wideBus ? dbuf.outData : {16'h0000, dbuf.outData[15:0]};

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cpuRdData_r <= 32'h0000_0000;
    end else if (rdStb) begin
      cpuRdData_r <= rdMux;
    end
  end

  always_ff @(posedge core_clk) begin
    // request level follows polarity
    // Full clear also returns the pin to the idle level of the reset polarity
    if (allClr) begin
      transferRequestOut_r <= 1'b1;
    end else begin
      transferRequestOut_r <= reqOn ? reqPol : ~reqPol;
    end
  end

  always_ff @(posedge core_clk) begin
    if (allClr) begin
      dmaDataOut_r <= 32'h0000_0000;
      dmaDataOe_r <= 1'b0;
      xferBusy_r <= 1'b0;
    end else begin
      if (dataOut) dmaDataOut_r <= outWord;
      dmaDataOe_r <= dataOut;
      xferBusy_r <= runOn & (remain_r != '0) & ~wrCfg;
    end
  end
endmodule : sdc_slave_dma

// *** testbench/sdc_chk_assertions.sv ***
`timescale 1ns/1ps
module sdc_chk
  import sdc_pkg::*;
#(
  parameter int RAM_WORDS = 256
) (
  input wire logic core_clk, // Clock
  input wire logic reset, // Reset
  input wire logic cpuCs, // Select
  input wire logic cpuWr, // Write strobe
  input wire logic cpuRd, // Read strobe
  input wire logic [sdc_pkg::ADDR_W-1:0] cpuAddr, // Address
  input wire logic [31:0] cpuWrData, // Write data
  input wire logic [31:0] cpuRdData_r, // Read data
  input wire logic transferRequestOut_r, // Request pin
  input wire logic transferAcknowledgeIn, // Acknowledge pin
  input wire logic [31:0] dmaDataIn, // Data in
  input wire logic [31:0] dmaDataOut_r, // Data out
  input wire logic dmaDataOe_r, // Data out valid
  input wire logic ramGrant, // RAM grant
  input wire logic xferBusy_r // Busy
);
  logic wrCfg, wrMode, wrSr, reqAct, reqPol_r, dir_r;
  assign wrCfg = cpuCs && cpuWr && cpuAddr == XFER_CFG_OFF;
  assign wrMode = cpuCs && cpuWr && cpuAddr == MODE_CTL_OFF;
  assign wrSr = cpuCs && cpuWr && cpuAddr == SOFT_RESET_OFF;
  assign reqAct = transferRequestOut_r == reqPol_r;
  // Shadow of polarity and direction
  always_ff @(posedge core_clk) begin
    if (reset || (wrSr && cpuWrData[SR_FULL_BIT])) begin
      reqPol_r <= 1'b0;
      dir_r <= 1'b0;
    end else begin
      if (wrMode) reqPol_r <= cpuWrData[MODE_REQ_POL_BIT];
      if (wrCfg) dir_r <= cpuWrData[CFG_DIR_BIT];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_start_busy: assert property (wrCfg && cpuWrData[1] && cpuWrData[31:8] != 24'h0 |=> ##1
    xferBusy_r && reqAct) else $error("start not seen");
  a_stop_idle: assert property (wrCfg && !cpuWrData[1] |=> !xferBusy_r && !reqAct)
    else $error("stop not seen");
  a_empty_idle: assert property (wrCfg && cpuWrData[31:8] == 24'h0 |=> !xferBusy_r)
    else $error("empty count ran");
  a_full_clear: assert property (wrSr && cpuWrData[0] |=> !xferBusy_r && !dmaDataOe_r
    && transferRequestOut_r) else $error("full reset missed");
  a_sr_reads: assert property (cpuCs && cpuRd && cpuAddr == SOFT_RESET_OFF |=>
    cpuRdData_r == 32'h0) else $error("soft reset read not zero");
  a_idle_level: assert property (!xferBusy_r ##1 !xferBusy_r && $stable(reqPol_r) |->
    transferRequestOut_r == !reqPol_r) else $error("idle request level wrong");
  a_gap_two: assert property ($fell(reqAct) && $stable(reqPol_r) && !wrCfg |=> !reqAct)
    else $error("burst gap too short");
  a_oe_dir: assert property (dmaDataOe_r |-> $past(dir_r))
    else $error("data out in write direction");
  cover property (wrCfg && cpuWrData[1]);
  cover property (dmaDataOe_r);
  cover property ($fell(xferBusy_r));
endmodule : sdc_chk
bind sdc_slave_dma sdc_chk #(.RAM_WORDS(RAM_WORDS)) sdc_chk_i (.*);

// *** testbench/sdc_dma_partner.sv ***
`timescale 1ns/1ps
module sdc_dma_partner (
  input wire logic core_clk, // Clock
  input wire logic clr, // Clear tallies
  input wire logic reqOut, // Request pin
  input wire logic reqPol, // Request active level
  input wire logic ackPol, // Acknowledge active level
  input wire logic slow, // Acknowledge every other cycle
  input wire logic [31:0] word, // Word offered
  output logic ackOut, // Acknowledge pin
  output logic [31:0] dataOut, // Data lines
  output int accesses, // Accesses seen
  output int burstMax // Longest burst seen
);
  logic ackOn = 1'b0;
  int run = 0;
  logic reqAct;
  assign reqAct = reqOut == reqPol;
  assign ackOut = ~(ackOn ^ ackPol);
  assign dataOut = ackOn ? word : ~word;
  always @(posedge core_clk) begin
    if (clr) begin
      accesses <= 0;
      burstMax <= 0;
      run <= 0;
    end else if (ackOn && reqAct) begin
      accesses <= accesses + 1;
      run <= run + 1;
      if (run + 1 > burstMax) burstMax <= run + 1;
    end else if (!reqAct) begin
      run <= 0;
    end
    ackOn <= reqAct && !(slow && ackOn);
  end
endmodule : sdc_dma_partner

// *** testbench/soft_reset_and_slave_dma_cfg_tb.sv ***
`timescale 1ns/1ps
module soft_reset_and_slave_dma_cfg_tb;
  import sdc_pkg::*;
  logic core_clk = 0, reset = 1, cpuCs = 0, cpuWr = 0, cpuRd = 0, ramGrant = 1, stall = 0;
  logic slow = 0, clr = 0, reqPol = 0, ackPol = 0, rdLag = 0, ack, req, oe, busy;
  logic [11:0] cpuAddr = 0;
  logic [31:0] cpuWrData = 0, word = 0, dIn, rdData, dOut;
  logic [31:0] expQ[$];
  int num_errors = 0, check_count = 0, oeCount = 0, accesses, burstMax;
  initial forever #4 core_clk = ~core_clk;
  sdc_slave_dma sdc_slave_dma_i (.core_clk(core_clk), .reset(reset), .cpuCs(cpuCs),
    .cpuWr(cpuWr), .cpuRd(cpuRd), .cpuAddr(cpuAddr), .cpuWrData(cpuWrData),
    .cpuRdData_r(rdData), .transferRequestOut_r(req), .transferAcknowledgeIn(ack),
    .dmaDataIn(dIn), .dmaDataOut_r(dOut), .dmaDataOe_r(oe), .ramGrant(ramGrant),
    .xferBusy_r(busy));
  sdc_dma_partner sdc_dma_partner_i (.core_clk(core_clk), .clr(clr), .reqOut(req),
    .reqPol(reqPol), .ackPol(ackPol), .slow(slow), .word(word), .ackOut(ack),
    .dataOut(dIn), .accesses(accesses), .burstMax(burstMax));
  ////////////////////////////////////////
  task check_value(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check_value
  task finish_test;
    if (num_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge core_clk) {cpuCs, cpuWr, cpuAddr, cpuWrData} = {2'b11, a, d};
    @(negedge core_clk) {cpuCs, cpuWr} = 2'b00;
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] e);
    expQ.push_back(e);
    @(negedge core_clk) {cpuCs, cpuRd, cpuAddr} = {2'b11, a};
    @(negedge core_clk) {cpuCs, cpuRd} = 2'b00;
  endtask : rd
  always @(posedge core_clk) begin
    rdLag <= cpuCs && cpuRd;
    if (oe) oeCount++;
  end
  always @(negedge core_clk) begin
    ramGrant <= !stall || 1'($urandom_range(0, 1));
    if (rdLag) check_value("read", rdData, expQ.pop_front());
  end
  initial begin
    #400000;
    num_errors++;
    finish_test;
  end
  ////////////////////////////////////////
  initial begin
    logic [31:0] m, cfg, h;
    int n, acc, beats;
    void'($urandom(66));
    repeat (16) @(negedge core_clk);
    reset = 0;
    rd(XFER_CFG_OFF, XFER_CFG_RST);
    rd(12'h310, 32'h0);
    h = $urandom;
    wr(HC_STATE_OFF, h);
    wr(MODE_CTL_OFF, 32'h160);
    wr(SOFT_RESET_OFF, 32'h2);
    rd(HC_STATE_OFF, 32'h0);
    rd(MODE_CTL_OFF, 32'h160);
    wr(HC_STATE_OFF, h);
    wr(SOFT_RESET_OFF, 32'h0);
    rd(HC_STATE_OFF, h);
    wr(SOFT_RESET_OFF, 32'h1);
    rd(MODE_CTL_OFF, 32'h0);
    rd(HC_STATE_OFF, 32'h0);
    for (int i = 0; i < 64; i++) begin
      n = $urandom_range(1, 48);
      m = {23'h0, i[0], 1'b0, i[1], i[2], 5'h0};
      cfg = {n[23:0], 4'h0, i[4:3], 1'b1, i[5]};
      {ackPol, reqPol, stall, slow} = {m[6], m[5], i[5], i[5] & i[1]};
      word = $urandom;
      wr(MODE_CTL_OFF, m);
      clr = 1;
      oeCount = 0;
      wr(XFER_CFG_OFF, cfg);
      clr = 0;
      @(negedge core_clk);
      for (int k = 0; k < 2000 && busy; k++) @(negedge core_clk);
      repeat (3) @(negedge core_clk);
      acc = (n + (i[0] ? 4 : 2) - 1) / (i[0] ? 4 : 2);
      beats = (i[4:3] == 2'b00) ? 1 : 2 << i[4:3];
      check_value("busy", busy, 32'h0);
      if (i[5]) check_value("words out", oeCount, acc);
      else begin
        check_value("accesses", accesses, acc);
        check_value("burst", burstMax, acc < beats ? acc : beats);
        rd(RAM_WIN_OFF, i[0] ? word : {16'h0, word[15:0]});
      end
      rd(XFER_CFG_OFF, {24'h0, cfg[7:0]});
    end
    {stall, slow} = 2'b00;
    clr = 1;
    wr(XFER_CFG_OFF, {24'd200, 8'h02});
    clr = 0;
    repeat (10) @(negedge core_clk);
    wr(XFER_CFG_OFF, 32'h0);
    check_value("aborted", {31'h0, accesses > 0 && accesses < 50 && !busy}, 32'h1);
    repeat (3) @(negedge core_clk);
    finish_test;
  end
endmodule : soft_reset_and_slave_dma_cfg_tb
